// >>> logic/flash_writer_pkg.sv
// Constants shared by the flash page buffer writer: register map, codes, timing.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package flash_writer_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PROG_TIME_MS = 4; // Typical erase+program time
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned US_CYCLES = 1000 / CLK_PERIOD_NS; // Unit of the emulation time
  localparam logic [10:0] WARMUP_CYCLES = 11'h400; // 2^10 system clock periods

  // ==========================================================================
  // Control codes and data values
  localparam logic [7:0] CODE_UNLOCK = 8'h3B;
  localparam logic [7:0] CODE_LOCK = 8'hCB;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [6:0] PAGE_BYTES = 7'h40;
  localparam logic [15:0] FLASH_BASE = 16'h8000;
  localparam logic [15:0] MCU_LAST = 16'h81FF;
  localparam logic [15:0] PROM_LAST = 16'hFFFF;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_EMU_TIME = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CTRL_POWER = 0;
  localparam int unsigned CTRL_UNLOCK = 1;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_WARM = 1;
  localparam int unsigned ST_WRITE_INTERRUPTED_FLAG = 2;
  localparam int unsigned ST_UNLOCK = 3;
  localparam int unsigned ST_COUNT = 4;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_ABORT = 1;
  localparam logic [15:0] EMU_TIME_RST = 16'h0FA0; // 4000 us
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_commit = 2'b10,
    st_warm = 2'b11
  } seq_e;

endpackage : flash_writer_pkg

// >>> logic/flash_page_buffer_writer.sv
// Flash page buffer writer: unlock, 64-byte page buffer, timed erase+program,
// commit of the page to the memory port, APB registers and one interrupt.
// Assumes the CPU core drives the store, read and event ports on clk, and that
// the flash array (or emulation memory) sits on the mem_* and array_rdata ports.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps

module flash_page_buffer_writer
  import flash_writer_pkg::*;
#(
  parameter bit EMULATION = 1'b0,
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU stores into the flash space
  input wire logic st_en,
  input wire logic st_word,
  input wire logic [15:0] st_addr,
  input wire logic [15:0] st_data,
  // CPU reads and fetches of the flash space
  input wire logic rd_en,
  input wire logic [7:0] array_rdata,
  output logic [7:0] rd_data,
  // Interrupt events from the core
  input wire logic nmi,
  input wire logic int_taken,
  // Mode pin: high selects serial PROM mode range
  input wire logic prom_mode_pin,
  // Page commit port to flash or emulation memory
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Sequencer state
  seq_e state, next_state;
  logic [31:0] timer, next_timer;
  logic [6:0] cnt, next_cnt;
  logic [6:0] idx, next_idx;
  logic [9:0] page, next_page;
  logic unlocked, next_unlocked;
  logic power, next_power;
  logic warm_done, next_warm_done;
  logic write_interrupted_flag, next_write_interrupted_flag;
  logic next_mem_we;
  logic [15:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic [7:0] buf_mem [0:63];
  logic [7:0] next_buf [0:63];
  logic ev_done, ev_abort;

  // Bus side state
  logic [15:0] emu_time, next_emu_time;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic [7:0] next_rd_data;
  logic prom_s1, prom_s2, prom_s3, prom_mode, next_prom_mode;

  // ==========================================================================
  // Decode shared by both groups
  logic busy, bus_wr, ctrl_wr, in_range, take_store, any_int;
  logic [31:0] target;
  logic [6:0] sum;
  logic mapped;

  assign busy = (state == st_busy) || (state == st_commit);
  assign bus_wr = psel && penable && pwrite;
  assign ctrl_wr = bus_wr && (paddr == OFS_CTRL);
  assign any_int = nmi || int_taken;
  // Range differs by mode; addresses outside it are ignored
  assign in_range = (st_addr >= FLASH_BASE) &&
                    (st_addr <= (prom_mode ? PROM_LAST : MCU_LAST));
  // An interrupt in the same cycle wins, so the fill is dropped cleanly
  assign take_store = st_en && in_range && unlocked && warm_done &&
                      (state == st_idle) && !any_int;
  assign sum = cnt + (st_word ? 7'h02 : 7'h01);
  // Zero emulation time would give no busy period, so it counts as one unit
  assign target = EMULATION ? ((emu_time == 16'h0000) ? US_CYCLES :
                  32'(emu_time) * US_CYCLES) : PROG_CYCLES;

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_cnt = cnt;
    next_idx = idx;
    next_page = page;
    next_unlocked = unlocked;
    next_power = power;
    next_warm_done = warm_done;
    next_write_interrupted_flag = write_interrupted_flag;
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_buf = buf_mem;
    ev_done = 1'b0;
    ev_abort = 1'b0;
    // Write-one clears the interrupted flag; a set below overrides it
    if (bus_wr && (paddr == OFS_STATUS) && pwdata[ST_WRITE_INTERRUPTED_FLAG]) begin
      next_write_interrupted_flag = 1'b0;
    end
    if (ctrl_wr) begin
      if (pwdata[7:0] == CODE_UNLOCK) begin
        next_unlocked = 1'b1;
      end else if (pwdata[7:0] == CODE_LOCK) begin
        next_unlocked = 1'b0;
        next_cnt = 7'h00;
      end
    end
    case (state)
      st_idle: begin
        if (take_store) begin
          if (cnt == 7'h00) begin
            next_page = st_addr[15:6];
          end
          next_buf[cnt[5:0]] = st_data[7:0];
          if (st_word && (cnt != 7'h3F)) begin
            next_buf[6'(cnt + 7'h01)] = st_data[15:8];
          end
          if (sum >= PAGE_BYTES) begin
            next_state = st_busy;
            next_timer = 32'h0;
            next_cnt = 7'h00;
          end else begin
            next_cnt = sum;
          end
        end else if (any_int && (cnt != 7'h00)) begin
          next_cnt = 7'h00;
        end
        if (nmi && !power) begin
          // NMI with flash powered down forces power on and a warm-up
          next_power = 1'b1;
          next_warm_done = 1'b0;
          next_state = st_warm;
          next_timer = 32'h0;
        end else if (ctrl_wr && !power && pwdata[CTRL_POWER]) begin
          next_power = 1'b1;
          next_warm_done = 1'b0;
          next_state = st_warm;
          next_timer = 32'h0;
        end else if (ctrl_wr && !pwdata[CTRL_POWER]) begin
          next_power = 1'b0;
          next_warm_done = 1'b0;
          next_cnt = 7'h00;
        end
      end
      st_busy: begin
        if (nmi) begin
          next_write_interrupted_flag = 1'b1;
          next_cnt = 7'h00;
          next_warm_done = 1'b0;
          next_state = st_warm;
          next_timer = 32'h0;
          ev_abort = 1'b1;
        end else if (timer + 32'h1 >= target) begin
          next_state = st_commit;
          next_idx = 7'h00;
        end else begin
          next_timer = timer + 32'h1;
        end
      end
      st_commit: begin
        // Memory is written only here, so an aborted page stays untouched
        if (idx == PAGE_BYTES) begin
          next_state = st_idle;
          ev_done = 1'b1;
        end else begin
          next_mem_we = 1'b1;
          next_mem_addr = {page, idx[5:0]};
          next_mem_wdata = buf_mem[idx[5:0]];
          next_idx = idx + 7'h01;
        end
      end
      st_warm: begin
        if (timer[10:0] == WARMUP_CYCLES - 11'h001) begin
          next_state = st_idle;
          next_warm_done = 1'b1;
        end else begin
          next_timer = timer + 32'h1;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // Sequencer registers; the buffer itself needs no reset
  always_ff @(posedge clk) begin
    buf_mem <= next_buf;
    if (rst) begin
      state <= st_warm;
      timer <= 32'h0;
      cnt <= 7'h00;
      idx <= 7'h00;
      page <= 10'h000;
      unlocked <= 1'b0;
      power <= 1'b1;
      warm_done <= 1'b0;
      write_interrupted_flag <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      state <= next_state;
      timer <= next_timer;
      cnt <= next_cnt;
      idx <= next_idx;
      page <= next_page;
      unlocked <= next_unlocked;
      power <= next_power;
      warm_done <= next_warm_done;
      write_interrupted_flag <= next_write_interrupted_flag;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // ==========================================================================
  // Bus side: registers, read data, mode pin filter
  always_comb begin
    next_emu_time = emu_time;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_prdata = prdata;
    next_rd_data = rd_data;
    // The mode pin only counts once the last two stages agree
    next_prom_mode = (prom_s2 == prom_s3) ? prom_s3 : prom_mode;
    if (bus_wr && (paddr == OFS_EMU_TIME)) begin
      next_emu_time = pwdata[15:0];
    end
    if (bus_wr && (paddr == OFS_IRQ_MASK)) begin
      next_irq_mask = pwdata[1:0];
    end
    if (bus_wr && (paddr == OFS_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~pwdata[1:0];
    end
    // Set after clear, so an event in the clearing cycle is kept
    next_irq_stat[IRQ_DONE] = next_irq_stat[IRQ_DONE] | ev_done;
    next_irq_stat[IRQ_ABORT] = next_irq_stat[IRQ_ABORT] | ev_abort;
    // Read data is captured in the setup phase and shown in the access phase
    if (psel && !penable) begin
      next_prdata = 32'h0;
      case (paddr)
        OFS_CTRL: begin
          next_prdata[CTRL_POWER] = power;
          next_prdata[CTRL_UNLOCK] = unlocked;
        end
        OFS_STATUS: begin
          next_prdata[ST_BUSY] = busy;
          next_prdata[ST_WARM] = warm_done;
          next_prdata[ST_WRITE_INTERRUPTED_FLAG] = write_interrupted_flag;
          next_prdata[ST_UNLOCK] = unlocked;
          next_prdata[ST_COUNT +: 7] = cnt;
        end
        OFS_EMU_TIME: next_prdata[15:0] = emu_time;
        OFS_IRQ_STAT: next_prdata[1:0] = irq_stat;
        OFS_IRQ_MASK: next_prdata[1:0] = irq_mask;
        default: next_prdata = 32'h0;
      endcase
    end
    // A fetched FFH traps, so nothing from the array leaks out while busy
    if (rd_en) begin
      next_rd_data = (busy || !warm_done) ? ERASED_BYTE : array_rdata;
    end
  end

  // Bus side registers
  always_ff @(posedge clk) begin
    prom_s1 <= prom_mode_pin;
    prom_s2 <= prom_s1;
    prom_s3 <= prom_s2;
    if (rst) begin
      emu_time <= EMU_TIME_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_stat <= 2'h0;
      prdata <= 32'h0;
      rd_data <= 8'h00;
      prom_mode <= 1'b0;
    end else begin
      emu_time <= next_emu_time;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      prdata <= next_prdata;
      rd_data <= next_rd_data;
      prom_mode <= next_prom_mode;
    end
  end

  // Zero wait states; unmapped offsets answer with an error
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_EMU_TIME) ||
                  (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(irq_stat & irq_mask);

  // Assertion helpers: cycles spent busy and in warm-up, too long for a repetition
  logic [31:0] busy_span;
  logic [10:0] warm_span;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_span <= 32'h0;
      warm_span <= 11'h000;
    end else begin
      busy_span <= busy ? busy_span + 32'h1 : 32'h0;
      warm_span <= (state == st_warm) ? warm_span + 11'h001 : 11'h000;
    end
  end

  // ==========================================================================
  // Assertions
  a_unlock_code: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && (pwdata[7:0] == CODE_UNLOCK) |=> unlocked)
    else $error("unlock code did not unlock");
  a_lock_code: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && (pwdata[7:0] == CODE_LOCK) |=> !unlocked && (cnt == 7'h00))
    else $error("lock code did not lock");
  a_busy_hold: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) && (state == st_idle) |->
    (busy_span == target + 32'(PAGE_BYTES) + 32'h00000001))
    else $error("busy period length wrong");
  a_read_ff: assert property (@(posedge clk) disable iff (rst)
    rd_en && busy |=> (rd_data == ERASED_BYTE))
    else $error("flash read while busy did not return FFH");
  a_first_page: assert property (@(posedge clk) disable iff (rst)
    take_store && (cnt == 7'h00) |=> (page == $past(st_addr[15:6])))
    else $error("page not taken from first byte address");
  a_first_slot: assert property (@(posedge clk) disable iff (rst)
    take_store && (cnt == 7'h00) |=> (buf_mem[0] == $past(st_data[7:0])))
    else $error("first byte not in slot zero");
  a_arrival_order: assert property (@(posedge clk) disable iff (rst)
    take_store && !st_word && (cnt == 7'h05) |=> (buf_mem[5] == $past(st_data[7:0])))
    else $error("byte not stored in arrival order");
  a_word_two: assert property (@(posedge clk) disable iff (rst)
    take_store && st_word && (cnt < 7'h3E) |=> (cnt == $past(cnt) + 7'h02))
    else $error("word store did not count two bytes");
  a_commit_before: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) && (state == st_idle) |-> $past(mem_we) && (mem_addr[5:0] == 6'h3F))
    else $error("busy fell without final commit write");
  a_nmi_abort: assert property (@(posedge clk) disable iff (rst)
    (state == st_busy) && nmi |=> !busy && write_interrupted_flag && (cnt == 7'h00) && !warm_done &&
    (state == st_warm) && (timer == 32'h0))
    else $error("NMI did not abort the write");
  a_warm_span: assert property (@(posedge clk) disable iff (rst)
    $rose(warm_done) |-> (warm_span == WARMUP_CYCLES))
    else $error("warm-up did not last 1024 cycles");
  a_partial_drop: assert property (@(posedge clk) disable iff (rst)
    (state == st_idle) && any_int && (cnt != 7'h00) |=> (cnt == 7'h00) && !busy)
    else $error("partial fill survived an interrupt");
  a_auto_start: assert property (@(posedge clk) disable iff (rst)
    take_store && (cnt == 7'h3F) |=> busy && (cnt == 7'h00))
    else $error("full buffer did not start programming");

endmodule : flash_page_buffer_writer

// >>> bench/flash_array_model.sv
// Behavioural flash array sitting on the page commit port of the writer.
// Assumes commit writes arrive on clk; the bench chooses the read address.
`timescale 1ns/1ps

module flash_array_model (
  // Clock
  input wire logic clk,
  // Commit port
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  // Read side
  input wire logic [15:0] rd_addr,
  output logic [7:0] array_rdata,
  output int wr_count
);
  // ==========================================================================
  // Storage
  logic [7:0] cells [0:65535];
  int writes = 0;

  // Unwritten cells hold the inverted low address byte, so old data looks erased only where that byte is 00H
  initial begin
    for (int i = 0; i < 65536; i++) begin
      cells[i] = ~i[7:0];
    end
  end

  // Commit writes, counted so that an aborted page shows as no writes at all
  always @(posedge clk) begin
    if (mem_we) begin
      cells[mem_addr] <= mem_wdata;
      writes <= writes + 1;
    end
  end

  // Read path is combinational; the writer registers it
  assign array_rdata = cells[rd_addr];
  assign wr_count = writes;
endmodule : flash_array_model

// >>> bench/flash_page_buffer_writer_test.sv
// Self-checking bench for the flash page buffer writer.
// Assumes the writer package, the design and the flash array model are compiled first.
`timescale 1ns/1ps

module flash_page_buffer_writer_test;
  import flash_writer_pkg::*;
  // ==========================================================================
  // Signals
  localparam int unsigned PROG = 200;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mem_we, irq, er;
  logic st_en = 1'h0;
  logic st_word = 1'h0;
  logic [15:0] st_addr = 16'h0000;
  logic [15:0] st_data = 16'h0000;
  logic rd_en = 1'h0;
  logic nmi = 1'h0;
  logic int_taken = 1'h0;
  logic prom_mode_pin = 1'h0;
  logic [7:0] array_rdata, rd_data, mem_wdata;
  logic [15:0] mem_addr;
  logic [15:0] peek_addr = 16'h0000;
  logic [31:0] rv;
  logic [31:0] seed = 32'h98D20B10;
  logic [7:0] page_exp [0:63];
  int wr_count;
  int failures = 0;
  int num_checks = 0;
  time t0;

  // Clock at 100 MHz
  always #5 clk = ~clk;

  // ==========================================================================
  // Design and far side
  flash_page_buffer_writer #(.EMULATION(1'h0), .PROG_CYCLES(PROG)) dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .st_en(st_en), .st_word(st_word), .st_addr(st_addr),
    .st_data(st_data), .rd_en(rd_en), .array_rdata(array_rdata), .rd_data(rd_data),
    .nmi(nmi), .int_taken(int_taken), .prom_mode_pin(prom_mode_pin),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .irq(irq));
  flash_array_model partner (.clk(clk), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .rd_addr(peek_addr), .array_rdata(array_rdata),
    .wr_count(wr_count));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Expected status word from its fields
  function automatic logic [31:0] st_exp(input logic b, w, i, u, input logic [6:0] c);
    return {21'h0, c, u, i, w, b};
  endfunction : st_exp

  task automatic complete_run;
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rv);
  endtask : rdchk

  task automatic wait_st(input int b, input logic v);
    do apb(1'h0, OFS_STATUS, 32'h0); while (rv[b] !== v);
  endtask : wait_st

  task automatic store(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    st_en <= 1'h1;
    st_word <= w;
    st_addr <= a;
    st_data <= d;
    @(posedge clk);
    st_en <= 1'h0;
  endtask : store

  // Read through the writer; rd_data lands one edge after rd_en
  task automatic cpu_read(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    peek_addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, rd_data});
  endtask : cpu_read

  // Interrupt accept pulse, optionally non-maskable
  task automatic int_evt(input logic n);
    @(posedge clk);
    nmi <= n;
    int_taken <= 1'h1;
    @(posedge clk);
    nmi <= 1'h0;
    int_taken <= 1'h0;
  endtask : int_evt

  // Random byte and word stores anywhere in the MCU range after a chosen first address
  task automatic fill(input logic [15:0] first, input int n);
    int k;
    logic [15:0] a;
    k = 0;
    while (k < n) begin
      seed = xs(seed);
      a = (k == 0) ? first : {7'h40, seed[24:16]};
      store(seed[0] && k < n - 1, a, seed[15:0]);
      page_exp[k] = seed[7:0];
      if (seed[0] && k < n - 1) page_exp[k + 1] = seed[15:8];
      k += (seed[0] && k < n - 1) ? 2 : 1;
    end
  endtask : fill

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rdchk(OFS_CTRL, 32'h1, "ctrl reset");
    rdchk(OFS_EMU_TIME, {16'h0, EMU_TIME_RST}, "emu time reset");
    rdchk(OFS_IRQ_MASK, 32'h0, "irq mask reset");
    rdchk(OFS_STATUS, st_exp(0, 0, 0, 0, 0), "status warming");
    cpu_read(16'h8040, ERASED_BYTE, "read warming");
    wait_st(ST_WARM, 1'h1);
    apb(1'h0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rv);
    store(1'h0, 16'h8040, 16'h0055);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 0, 0), "locked store");
    cpu_read(16'h8043, 8'hBC, "idle read");
    apb(1'h1, OFS_IRQ_MASK, 32'h1);
    apb(1'h1, OFS_CTRL, {24'h0, CODE_UNLOCK});
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 0), "unlock");
    store(1'h0, 16'h8200, 16'h0011);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 0), "out of range");
    // Odd first address, random addresses later, a word at the last slot
    fill(16'h8045, 63);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 63), "count 63");
    seed = xs(seed);
    page_exp[63] = seed[7:0];
    store(1'h1, 16'h81F0, seed[15:0]);
    t0 = $time;
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("busy set", 32'hB, rv & 32'hF);
    cpu_read(16'h8045, ERASED_BYTE, "read busy");
    store(1'h0, 16'h8040, 16'h00AA);
    wait_st(ST_BUSY, 1'h0);
    chk("busy span", 32'h1, (($time - t0) / 10 >= PROG + 60) && (($time - t0) / 10 <= PROG + 72));
    chk("commit writes", 32'd64, wr_count);
    for (int i = 0; i < 64; i++) begin
      peek_addr = 16'h8040 + i[15:0];
      #1;
      chk("page byte", {24'h0, page_exp[i]}, {24'h0, array_rdata});
    end
    chk("irq done", 32'h1, irq);
    apb(1'h1, OFS_CTRL, {24'h0, CODE_LOCK});
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 0, 0), "lock");
    apb(1'h1, OFS_IRQ_STAT, 32'h1);
    #1;
    chk("irq cleared", 32'h0, irq);
    // Partial page cut short by an interrupt
    apb(1'h1, OFS_CTRL, {24'h0, CODE_UNLOCK});
    fill(16'h80C0, 10);
    int_evt(1'h0);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 0), "partial dropped");
    // Full page aborted by a non-maskable interrupt while busy
    fill(16'h8100, 64);
    int_evt(1'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("nmi abort", st_exp(0, 0, 1, 0, 0), rv & 32'h7F7);
    chk("abort writes", 32'd64, wr_count);
    chk("irq masked", 32'h0, irq);
    apb(1'h1, OFS_IRQ_MASK, 32'h3);
    #1;
    chk("irq abort", 32'h1, irq);
    wait_st(ST_WARM, 1'h1);
    cpu_read(16'h80C1, 8'h3E, "page kept");
    cpu_read(16'h8107, 8'hF8, "aborted page kept");
    apb(1'h1, OFS_STATUS, 32'h4);
    apb(1'h1, OFS_IRQ_STAT, 32'h3);
    #1;
    chk("irq off", 32'h0, irq);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 0), "write_interrupted_flag cleared");
    // Serial PROM range admits addresses above the MCU limit
    prom_mode_pin <= 1'h1;
    repeat (6) @(posedge clk);
    store(1'h0, 16'hC000, 16'h0077);
    rdchk(OFS_STATUS, st_exp(0, 1, 0, 1, 1), "prom range");
    complete_run;
  end

  // Watchdog against a hung handshake or a busy flag that never drops
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule : flash_page_buffer_writer_test
